// ==== pkg/tdi_pkg.sv ====
// tdi_pkg: register map, config carrier and frame constants for the trunk drop/insert block
// assumes a 32-bit word register port and a framed E1 or T1 trunk bit stream
package tdi_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SLOTS = 32;
   localparam int CNT_W = 6;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_DROP_MASK = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_INS_MASK = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_FRAMES = 8'h10;
   localparam int CTRL_T1 = 0;
   localparam int CTRL_DROP_EN = 1;
   localparam int CTRL_INS_EN = 2;
   localparam int CTRL_INT_FRAME = 3;
   localparam int ST_DROP_ERR = 0;
   localparam int ST_INS_ERR = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_PEND = 3;
   localparam int ST_DROP_CNT_LSB = 8;
   localparam int ST_INS_CNT_LSB = 16;
   localparam int CHAN_RATE_KBPS = 64;
   localparam logic [7:0] E1_LAST_POS = 8'hff;
   localparam logic [7:0] T1_LAST_POS = 8'hc0;
   localparam logic [7:0] POS_FIRST = 8'h00;
   localparam logic [7:0] POS_ONE = 8'h01;
   localparam logic [31:0] T1_SLOT_LEGAL = 32'h00ffffff;
   localparam logic [31:0] E1_SLOT_LEGAL = 32'hfffffffe;
   localparam logic [DATA_W-1:0] WORD_ONE = 32'h00000001;
   localparam logic [7:0] IDLE_CODE_DEF = 8'hd5;
   localparam logic [7:0] ALIGN_WORD_DEF = 8'h1b;

   typedef struct packed {
      logic t1;
      logic drop_en;
      logic ins_en;
      logic int_frame;
      logic [SLOTS-1:0] drop_mask;
      logic [SLOTS-1:0] ins_mask;
   } tdi_cfg_s;

   localparam tdi_cfg_s CFG_RESET = '0;

   function automatic logic [CNT_W-1:0] tdi_popcount(input logic [SLOTS-1:0] m);
      logic [CNT_W-1:0] c;
      c = '0;
      for (int i = 0; i < SLOTS; i++) begin
         c = c + {{(CNT_W-1){1'b0}}, m[i]};
      end
      return c;
   endfunction

   // allowed n: 1,2,4,6,8,12,16,24 and, on E1 only, 30
   function automatic logic tdi_count_ok(input logic [CNT_W-1:0] n, input logic t1);
      logic ok;
      ok = 1'b0;
      case (n)
         6'd1, 6'd2, 6'd4, 6'd6, 6'd8, 6'd12, 6'd16, 6'd24: ok = 1'b1;
         6'd30: ok = !t1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction
endpackage

// ==== src/tdi_drop_insert.sv ====
// tdi_drop_insert: timeslot drop and insert between a framed trunk and an n x 64k channel
// assumes trunk data and frame syncs are timed by trunk_clk, registers by sys_clk
//
// Function
// - copy only selected send-trunk timeslots out as the satellite drop stream
// - repeat the whole send trunk unchanged on the through output
// - buffer insert trunk and overwrite selected timeslots with satellite data
// - emit the modified trunk, unselected slots carried through from insert trunk
// - drop and insert selections are independent settings
// - channel is an integer count of 64k timeslots
// - satellite and receive-output timing both follow the trunk clock
// - through and receive outputs can feed the next unit in a chain
// - internal frame source builds the frame and idles non-inserted slots
// - E1 counts limited to 1,2,4,6,8,12,16,24 or 30
`timescale 1ns/1ns
`default_nettype none
module tdi_drop_insert
   import tdi_pkg::*;
#(
   parameter logic [7:0] IDLE_CODE = IDLE_CODE_DEF,
   parameter logic [7:0] ALIGN_WORD = ALIGN_WORD_DEF
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic trunk_clk,
   input wire logic send_trunk_in,
   input wire logic send_frame_sync,
   output logic send_trunk_through_out,
   output logic drop_bit,
   output logic drop_valid,
   input wire logic insert_trunk_in,
   input wire logic insert_frame_sync,
   input wire logic sat_rx_data,
   output logic sat_rx_take,
   output logic receive_trunk_out,
   output logic receive_frame_out
);

   // ---------------- register side (sys_clk) ----------------
   tdi_cfg_s stage;
   tdi_cfg_s good;
   tdi_cfg_s xfer;
   logic req_tgl;
   logic ack_s1;
   logic ack_s2;
   logic pend;
   logic drop_err;
   logic ins_err;
   logic frm_s1;
   logic frm_s2;
   logic frm_s3;
   logic [DATA_W-1:0] frames;
   logic [DATA_W-1:0] rdata;

   tdi_cfg_s next_stage;
   tdi_cfg_s next_good;
   tdi_cfg_s next_xfer;
   logic next_req_tgl;
   logic next_pend;
   logic next_drop_err;
   logic next_ins_err;
   logic [DATA_W-1:0] next_frames;
   logic [DATA_W-1:0] next_rdata;

   logic busy;
   logic cfg_wr;
   logic drop_ok;
   logic ins_ok;
   logic [SLOTS-1:0] legal;
   logic [CNT_W-1:0] drop_cnt;
   logic [CNT_W-1:0] ins_cnt;

   // trunk-side state that the register side samples through synchronisers
   logic tgl_s3;
   logic frm_tgl;

   assign busy = req_tgl ^ ack_s2;

   always_comb begin
      next_stage = stage;
      cfg_wr = 1'b0;
      if (reg_wr) begin
         if (reg_addr == ADDR_CTRL) begin
            next_stage.t1 = reg_wdata[CTRL_T1];
            next_stage.drop_en = reg_wdata[CTRL_DROP_EN];
            next_stage.ins_en = reg_wdata[CTRL_INS_EN];
            next_stage.int_frame = reg_wdata[CTRL_INT_FRAME];
            cfg_wr = 1'b1;
         end else if (reg_addr == ADDR_DROP_MASK) begin
            next_stage.drop_mask = reg_wdata[SLOTS-1:0];
            cfg_wr = 1'b1;
         end else if (reg_addr == ADDR_INS_MASK) begin
            next_stage.ins_mask = reg_wdata[SLOTS-1:0];
            cfg_wr = 1'b1;
         end
      end
   end

   // a function that is switched off may hold any mask, so masks can be set up one by one
   always_comb begin
      legal = next_stage.t1 ? T1_SLOT_LEGAL : E1_SLOT_LEGAL;
      drop_cnt = tdi_popcount(next_stage.drop_mask);
      ins_cnt = tdi_popcount(next_stage.ins_mask);
      drop_ok = !next_stage.drop_en || (tdi_count_ok(drop_cnt, next_stage.t1)
         && ((next_stage.drop_mask & ~legal) == '0));
      ins_ok = !next_stage.ins_en || (tdi_count_ok(ins_cnt, next_stage.t1)
         && ((next_stage.ins_mask & ~legal) == '0));
   end

   always_comb begin
      next_good = good;
      next_xfer = xfer;
      next_req_tgl = req_tgl;
      next_pend = pend;
      next_drop_err = drop_err;
      next_ins_err = ins_err;
      if (pend && !busy) begin
         next_xfer = good;
         next_req_tgl = !req_tgl;
         next_pend = 1'b0;
      end
      if (cfg_wr) begin
         next_drop_err = !drop_ok;
         next_ins_err = !ins_ok;
         if (drop_ok && ins_ok) begin
            next_good = next_stage;
            next_pend = 1'b1;
         end
      end
   end

   always_comb begin
      next_frames = frames;
      if (frm_s2 ^ frm_s3) begin
         next_frames = frames + WORD_ONE;
      end
      next_rdata = '0;
      if (reg_rd) begin
         if (reg_addr == ADDR_CTRL) begin
            next_rdata[CTRL_T1] = stage.t1;
            next_rdata[CTRL_DROP_EN] = stage.drop_en;
            next_rdata[CTRL_INS_EN] = stage.ins_en;
            next_rdata[CTRL_INT_FRAME] = stage.int_frame;
         end else if (reg_addr == ADDR_DROP_MASK) begin
            next_rdata[SLOTS-1:0] = stage.drop_mask;
         end else if (reg_addr == ADDR_INS_MASK) begin
            next_rdata[SLOTS-1:0] = stage.ins_mask;
         end else if (reg_addr == ADDR_STATUS) begin
            next_rdata[ST_DROP_ERR] = drop_err;
            next_rdata[ST_INS_ERR] = ins_err;
            next_rdata[ST_BUSY] = busy;
            next_rdata[ST_PEND] = pend;
            next_rdata[ST_DROP_CNT_LSB +: CNT_W] = tdi_popcount(good.drop_mask);
            next_rdata[ST_INS_CNT_LSB +: CNT_W] = tdi_popcount(good.ins_mask);
         end else if (reg_addr == ADDR_FRAMES) begin
            next_rdata = frames;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         stage <= CFG_RESET;
         good <= CFG_RESET;
         xfer <= CFG_RESET;
         req_tgl <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         pend <= 1'b0;
         drop_err <= 1'b0;
         ins_err <= 1'b0;
         frm_s1 <= 1'b0;
         frm_s2 <= 1'b0;
         frm_s3 <= 1'b0;
         frames <= '0;
         rdata <= '0;
      end else begin
         stage <= next_stage;
         good <= next_good;
         xfer <= next_xfer;
         req_tgl <= next_req_tgl;
         ack_s1 <= tgl_s3;
         ack_s2 <= ack_s1;
         pend <= next_pend;
         drop_err <= next_drop_err;
         ins_err <= next_ins_err;
         frm_s1 <= frm_tgl;
         frm_s2 <= frm_s1;
         frm_s3 <= frm_s2;
         frames <= next_frames;
         rdata <= next_rdata;
      end
   end

   assign reg_rdata = rdata;

   // ---------------- trunk side (trunk_clk) ----------------
   // the trunk clock times the drop stream and the receive output alike
   logic rst_s1;
   logic rst_s2;
   logic tgl_s1;
   logic tgl_s2;
   tdi_cfg_s cfg_trk;
   logic [7:0] send_pos;
   logic [7:0] ins_pos;
   logic through;
   logic dbit;
   logic dval;
   logic rx_out;
   logic rx_take;
   logic rx_frm;

   tdi_cfg_s next_cfg_trk;
   logic [7:0] next_send_pos;
   logic [7:0] next_ins_pos;
   logic next_dbit;
   logic next_dval;
   logic next_rx_out;
   logic next_rx_take;
   logic next_rx_frm;
   logic next_frm_tgl;
   logic next_tgl_s3;
   logic [7:0] s_cur;
   logic [7:0] i_cur;
   logic [7:0] last_pos;
   logic [7:0] s_off;
   logic [7:0] i_off;
   logic s_fbit;
   logic i_fbit;
   logic [4:0] s_slot;
   logic [4:0] i_slot;
   logic [2:0] i_bit;
   logic ins_here;
   logic fill_bit;
   always_comb begin
      next_cfg_trk = cfg_trk;
      last_pos = cfg_trk.t1 ? T1_LAST_POS : E1_LAST_POS;
      s_cur = send_frame_sync ? POS_FIRST : send_pos;
      if ((tgl_s2 ^ tgl_s3) && (s_cur == POS_FIRST)) begin
         next_cfg_trk = xfer;
      end
      i_cur = (insert_frame_sync && !cfg_trk.int_frame) ? POS_FIRST : ins_pos;
      s_fbit = cfg_trk.t1 && (s_cur == POS_FIRST);
      i_fbit = cfg_trk.t1 && (i_cur == POS_FIRST);
      s_off = cfg_trk.t1 ? s_cur - POS_ONE : s_cur;
      i_off = cfg_trk.t1 ? i_cur - POS_ONE : i_cur;
      s_slot = s_off[7:3];
      i_slot = i_off[7:3];
      i_bit = i_off[2:0];
      next_send_pos = (s_cur == last_pos) ? POS_FIRST : s_cur + POS_ONE;
      next_ins_pos = (i_cur == last_pos) ? POS_FIRST : i_cur + POS_ONE;
      next_frm_tgl = (s_cur == POS_FIRST) ? !frm_tgl : frm_tgl;
      next_tgl_s3 = (s_cur == POS_FIRST) ? tgl_s2 : tgl_s3;
   end

   always_comb begin
      next_dbit = send_trunk_in;
      next_dval = cfg_trk.drop_en && !s_fbit && cfg_trk.drop_mask[s_slot];
      ins_here = cfg_trk.ins_en && !i_fbit && cfg_trk.ins_mask[i_slot];
      // internal frame: align word in slot 0 on E1, F bit low on T1, idle elsewhere
      if (i_fbit) begin
         fill_bit = 1'b0;
      end else if (!cfg_trk.t1 && (i_slot == '0)) begin
         fill_bit = ALIGN_WORD[3'd7 - i_bit];
      end else begin
         fill_bit = IDLE_CODE[3'd7 - i_bit];
      end
      if (ins_here) begin
         next_rx_out = sat_rx_data;
      end else if (cfg_trk.int_frame) begin
         next_rx_out = fill_bit;
      end else begin
         next_rx_out = insert_trunk_in;
      end
      next_rx_take = ins_here;
      next_rx_frm = (i_cur == POS_FIRST);
   end

   // local reset release is synchronised so trunk counters leave reset on a clean edge
   always_ff @(posedge trunk_clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   always_ff @(posedge trunk_clk or negedge rst_s2) begin
      if (!rst_s2) begin
         tgl_s1 <= 1'b0;
         tgl_s2 <= 1'b0;
         tgl_s3 <= 1'b0;
         cfg_trk <= CFG_RESET;
         send_pos <= POS_FIRST;
         ins_pos <= POS_FIRST;
         through <= 1'b0;
         dbit <= 1'b0;
         dval <= 1'b0;
         rx_out <= 1'b0;
         rx_take <= 1'b0;
         rx_frm <= 1'b0;
         frm_tgl <= 1'b0;
      end else begin
         tgl_s1 <= req_tgl;
         tgl_s2 <= tgl_s1;
         tgl_s3 <= next_tgl_s3;
         cfg_trk <= next_cfg_trk;
         send_pos <= next_send_pos;
         ins_pos <= next_ins_pos;
         through <= send_trunk_in;
         dbit <= next_dbit;
         dval <= next_dval;
         rx_out <= next_rx_out;
         rx_take <= next_rx_take;
         rx_frm <= next_rx_frm;
         frm_tgl <= next_frm_tgl;
      end
   end

   assign send_trunk_through_out = through;
   assign drop_bit = dbit;
   assign drop_valid = dval;
   assign receive_trunk_out = rx_out;
   assign sat_rx_take = rx_take;
   assign receive_frame_out = rx_frm;

endmodule // tdi_drop_insert
`default_nettype wire

// ==== test/tdi_drop_insert_sva.sv ====
// tdi_drop_insert_sva: port properties of the drop/insert block
// assumes bind to every tdi_drop_insert instance
`timescale 1ns/1ns
`default_nettype none
module tdi_drop_insert_sva
   import tdi_pkg::*;
(
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic trunk_clk,
   input wire logic send_trunk_in,
   input wire logic send_frame_sync,
   input wire logic send_trunk_through_out,
   input wire logic drop_bit,
   input wire logic drop_valid,
   input wire logic sat_rx_data,
   input wire logic sat_rx_take,
   input wire logic receive_trunk_out,
   input wire logic receive_frame_out
);
   logic [2:0] t_up;
   logic up;
   assign up = (t_up == 3'h7);
   // skip early edges: trunk side leaves reset through a synchroniser
   always_ff @(posedge trunk_clk or negedge nrst) begin
      if (!nrst) t_up <= 3'h0;
      else if (!up) t_up <= t_up + 3'h1;
   end
   sequence s_slot_run;
      drop_valid [*8];
   endsequence
   sequence s_frame_gap;
      !receive_frame_out [*8];
   endsequence
   property p_through;
      @(posedge trunk_clk) disable iff (!nrst)
      up |-> send_trunk_through_out == $past(send_trunk_in);
   endproperty
   property p_drop_bit;
      @(posedge trunk_clk) disable iff (!nrst)
      up && drop_valid |-> drop_bit == $past(send_trunk_in);
   endproperty
   property p_insert;
      @(posedge trunk_clk) disable iff (!nrst)
      up && sat_rx_take |-> receive_trunk_out == $past(sat_rx_data);
   endproperty
   property p_drop_run;
      @(posedge trunk_clk) disable iff (!nrst) up && $rose(drop_valid) |-> s_slot_run;
   endproperty
   property p_frame_gap;
      @(posedge trunk_clk) disable iff (!nrst) up && receive_frame_out |=> s_frame_gap;
   endproperty
   property p_frame_no_take;
      @(posedge trunk_clk) disable iff (!nrst) receive_frame_out |-> !sat_rx_take;
   endproperty
   property p_sync_no_drop;
      @(posedge trunk_clk) disable iff (!nrst) up && $past(send_frame_sync) |-> !drop_valid;
   endproperty
   property p_rd_idle;
      @(posedge sys_clk) disable iff (!nrst) !$past(reg_rd) |-> reg_rdata == '0;
   endproperty
   a_through: assert property (p_through) else $error("through bit wrong");
   a_drop_bit: assert property (p_drop_bit) else $error("drop bit wrong");
   a_insert: assert property (p_insert) else $error("inserted bit wrong");
   a_drop_run: assert property (p_drop_run) else $error("partial slot");
   a_frame_gap: assert property (p_frame_gap) else $error("frame mark early");
   a_frame_no_take: assert property (p_frame_no_take) else $error("take at frame");
   a_sync_no_drop: assert property (p_sync_no_drop) else $error("slot 0 dropped");
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule // tdi_drop_insert_sva
bind tdi_drop_insert tdi_drop_insert_sva u_sva (.sys_clk(sys_clk), .nrst(nrst),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trunk_clk(trunk_clk),
   .send_trunk_in(send_trunk_in), .send_frame_sync(send_frame_sync),
   .send_trunk_through_out(send_trunk_through_out), .drop_bit(drop_bit),
   .drop_valid(drop_valid), .sat_rx_data(sat_rx_data), .sat_rx_take(sat_rx_take),
   .receive_trunk_out(receive_trunk_out), .receive_frame_out(receive_frame_out));
`default_nettype wire

// ==== test/tdi_trunk_model.sv ====
// tdi_trunk_model: framed E1 trunk and satellite source
// assumes the bench supplies trunk_clk; 256 bit positions a frame
`timescale 1ns/1ns
`default_nettype none
module tdi_trunk_model (
   input wire logic trunk_clk,
   input wire logic nrst,
   output logic send_trunk_in,
   output logic send_frame_sync,
   output logic insert_trunk_in,
   output logic insert_frame_sync,
   output logic sat_rx_data
);
   logic [7:0] pos;
   logic [7:0] next_pos;
   // one clock times drop, insert and satellite sides alike
   always_comb next_pos = pos + 8'h01;
   always_ff @(posedge trunk_clk or negedge nrst) begin
      if (!nrst) pos <= 8'h00;
      else pos <= next_pos;
   end
   // a single unit stands on the trunk, so chain order holds trivially
   assign send_frame_sync = (pos == 8'h00);
   assign insert_frame_sync = (pos == 8'h00);
   // patterns differ per stream so a swapped source shows up
   assign send_trunk_in = pos[0] ^ pos[3] ^ pos[6];
   assign insert_trunk_in = pos[1] ^ pos[4] ^ pos[7];
   assign sat_rx_data = pos[0] ^ pos[2] ^ pos[5];
endmodule // tdi_trunk_model
`default_nettype wire

// ==== test/trunk_timeslot_drop_insert_tb_top.sv ====
// trunk_timeslot_drop_insert_tb_top: register and trunk scenarios
// assumes E1 framing from tdi_trunk_model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module trunk_timeslot_drop_insert_tb_top;
   import tdi_pkg::*;
   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] a;
      logic [DATA_W-1:0] d;
      logic [DATA_W-1:0] e;
   } tdi_row_s;
   logic sys_clk, trunk_clk, nrst, reg_wr, reg_rd, ins_prev, mon_on;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, v, f0, dv, tk, fo;
   logic sti, sfs, iti, ifs, srd, thr, dbit, dval, take, rto, rfo;
   int n_fail, checked, pass_err;
   logic [DATA_W-1:0] bad [2] = '{32'h0000000e, 32'h00000001};
   tdi_row_s rows [5] = '{'{1'b0, ADDR_CTRL, 32'h0, 32'h0},
      '{1'b1, ADDR_DROP_MASK, 32'h0000001e, 32'h0000001e},
      '{1'b1, ADDR_INS_MASK, 32'h00000300, 32'h00000300},
      '{1'b1, ADDR_CTRL, 32'h00000006, 32'h00000006}, '{1'b0, 8'h14, 32'h0, 32'h0}};
   tdi_drop_insert u_tdi_drop_insert (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .trunk_clk(trunk_clk), .send_trunk_in(sti), .send_frame_sync(sfs),
      .send_trunk_through_out(thr), .drop_bit(dbit), .drop_valid(dval),
      .insert_trunk_in(iti), .insert_frame_sync(ifs), .sat_rx_data(srd),
      .sat_rx_take(take), .receive_trunk_out(rto), .receive_frame_out(rfo));
   tdi_trunk_model u_tdi_trunk_model (.trunk_clk(trunk_clk), .nrst(nrst),
      .send_trunk_in(sti), .send_frame_sync(sfs), .insert_trunk_in(iti),
      .insert_frame_sync(ifs), .sat_rx_data(srd));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      trunk_clk = 1'b0;
      #7;
      forever #40 trunk_clk = ~trunk_clk;
   end
   // unselected insert slots must leave as they came in
   always @(posedge trunk_clk) begin
      if (mon_on && !take && rto !== ins_prev) pass_err++;
      ins_prev <= iti;
   end
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic frame();
      dv = '0;
      tk = '0;
      fo = '0;
      @(posedge trunk_clk iff sfs);
      repeat (256) begin
         @(posedge trunk_clk);
         dv = dv + 32'(dval);
         tk = tk + 32'(take);
         fo = fo + 32'(rfo);
      end
   endtask
   task automatic end_of_test();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      n_fail++;
      end_of_test();
   end
   initial begin
      nrst = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      mon_on = 1'b0;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].wr) wr(rows[i].a, rows[i].d);
         rd(rows[i].a, v);
         chk(v, rows[i].e);
      end
      repeat (800) @(posedge trunk_clk);
      rd(ADDR_STATUS, v);
      chk(v & 32'h003f3f0f, 32'h00020400);
      $display("register test done");
      mon_on = 1'b1;
      frame();
      mon_on = 1'b0;
      chk(dv, 32'd32);
      chk(tk, 32'd16);
      chk(32'(pass_err), 32'd0);
      @(posedge trunk_clk);
      rd(ADDR_FRAMES, f0);
      repeat (256) @(posedge trunk_clk);
      rd(ADDR_FRAMES, v);
      chk(v - f0, 32'd1);
      $display("traffic test done");
      foreach (bad[i]) begin
         wr(ADDR_DROP_MASK, bad[i]);
         repeat (600) @(posedge trunk_clk);
         rd(ADDR_STATUS, v);
         chk(v & 32'h00003f03, 32'h00000401);
         rd(ADDR_DROP_MASK, v);
         chk(v, bad[i]);
      end
      frame();
      chk(dv, 32'd32);
      $display("refusal test done");
      wr(ADDR_CTRL, 32'h0000000c);
      repeat (800) @(posedge trunk_clk);
      frame();
      chk(tk, 32'd16);
      chk(fo, 32'd1);
      chk(dv, 32'd0);
      $display("internal frame test done");
      wr(ADDR_CTRL, 32'h00000005);
      wr(ADDR_INS_MASK, 32'h01000000);
      rd(ADDR_STATUS, v);
      chk(v & 32'h00000003, 32'h00000002);
      wr(ADDR_INS_MASK, 32'h7ffffffe);
      rd(ADDR_STATUS, v);
      chk(v & 32'h00000003, 32'h00000002);
      wr(ADDR_CTRL, 32'h00000004);
      rd(ADDR_STATUS, v);
      chk(v & 32'h00000003, 32'h00000000);
      $display("count limit test done");
      nrst <= 1'b0;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(ADDR_CTRL, v);
      chk(v, 32'h0);
      rd(ADDR_INS_MASK, v);
      chk(v, 32'h0);
      $display("reset test done");
      end_of_test();
   end
endmodule // trunk_timeslot_drop_insert_tb_top
`default_nettype wire
